// *** src/rtf_request_filter.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Reply only after a correctly decoded request
// - Response: flags, parameters, data, two-byte CRC
// - Frames carry whole bytes only
// - Bytes and fields go least significant first
// - Optional field present only when flag set
// - Four tag states
// - Off without energy, ready with energy
// - Ready answers when select indicator clear
// - Quiet ignores inventory and unaddressed requests
// - Selected answers select, matching and general requests
// - Indicator combinations decide answer; both gives 03h
// - Power-off needs no supply and no field
// - Addressed: compare identifier, answer only on match
// - Non-addressed requests executed by ready and selected tags
// - Select requests executed only when selected
// - Flag bit 3 switches meaning of bits 5-8
// - Flag bit 1 picks one or two subcarriers
// - Flag bit 2 picks low or high rate
// - Flag bit 4 marks protocol format extension
// - Bad CRC from all-ones preset drops frame
// - Bit 5 select, bit 6 address; both set answers with error
// - Response error bit means error code present
module rtf_request_filter
    import rtf_pkg::*;
#(
    parameter logic [63:0] ID_RESET       = 64'h0000_0000_0000_0000, // Arbitrary value
    parameter logic [7:0]  CMD_STAY_QUIET = 8'h02,
    parameter logic [7:0]  CMD_SELECT     = 8'h25,
    parameter logic [7:0]  CMD_RESET_RDY  = 8'h26
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Power sensing pins
    input  wire logic        field_ok,
    input  wire logic        vcc_ok,
    // Decoded request stream
    input  wire rtf_rx_s     rx,
    // Response frame setup
    output rtf_resp_s        resp,
    output rtf_tag_e         tag_state,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    rtf_state_s r_reg;
    rtf_state_s r_next;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int i = 0; i < 8; i++) begin
            // Reflected update consumes the byte least significant bit first
            if (x[0] ^ d[i]) begin
                x = (x >> 1) ^ RTF_CRC_POLY;
            end else begin
                x = x >> 1;
            end
        end
        return x;
    endfunction : crc_step

    always_comb begin
        logic       inv;
        logic       sel;
        logic       addr;
        logic       both;
        logic       addressed;
        logic [4:0] need;
        logic       good;
        logic       answer;
        logic       setup;
        logic       access;
        logic       hit;
        inv       = 1'b0;
        sel       = 1'b0;
        addr      = 1'b0;
        both      = 1'b0;
        addressed = 1'b0;
        need      = RTF_LEN_BASE;
        good      = 1'b0;
        answer    = 1'b0;
        setup     = 1'b0;
        access    = 1'b0;
        hit       = 1'b0;
        r_next    = r_reg;

        r_next.field_m    = field_ok;
        r_next.field_s    = r_reg.field_m;
        r_next.vcc_m      = vcc_ok;
        r_next.vcc_s      = r_reg.vcc_m;
        r_next.resp.start = 1'b0;

        // Flag decoding of the stored request flag byte
        inv       = r_reg.flags[RTF_RQ_INV];
        sel       = ~inv & r_reg.flags[RTF_RQ_SEL];
        addr      = ~inv & r_reg.flags[RTF_RQ_ADDR];
        both      = sel & addr;
        addressed = addr & ~sel;

        // Mandatory length: flags, command and CRC, plus present optional fields
        need = RTF_LEN_BASE;
        if (addressed) begin
            need = RTF_LEN_BASE + RTF_LEN_ID;
        end else if (inv) begin
            need = RTF_LEN_BASE + RTF_LEN_BYTE
                 + (r_reg.flags[RTF_RQ_AFI] ? RTF_LEN_BYTE : 5'h00);
        end

        if (rx.sof) begin
            r_next.active = r_reg.ctrl_en && (r_reg.tag != RTF_POWER_OFF);
            r_next.cnt    = 5'h00;
            r_next.crc    = RTF_CRC_PRESET;
            r_next.flags  = 8'h00;
            r_next.cmd    = 8'h00;
            r_next.id_ok  = 1'b1;
            r_next.id_sh  = r_reg.id;
        end else if (rx.byte_valid && r_reg.active) begin
            r_next.crc = crc_step(r_reg.crc, rx.data);
            if (r_reg.cnt != RTF_LEN_MAX) begin
                r_next.cnt = r_reg.cnt + RTF_LEN_BYTE;
            end
            if (r_reg.cnt == 5'h00) begin
                r_next.flags = rx.data;
            end
            if (r_reg.cnt == 5'h01) begin
                r_next.cmd = rx.data;
            end
            // Identifier arrives least significant byte first
            if (addressed && r_reg.cnt >= RTF_IDX_ID_LO && r_reg.cnt <= RTF_IDX_ID_HI) begin
                r_next.id_ok = r_reg.id_ok & (rx.data == r_reg.id_sh[7:0]);
                r_next.id_sh = {8'h00, r_reg.id_sh[63:8]};
            end
        end else if (rx.eof && r_reg.active) begin
            r_next.active = 1'b0;
            good = ~rx.bit_err && (r_reg.cnt >= need)
                 && (r_reg.crc == RTF_CRC_RESIDUE)
                 && (r_reg.tag != RTF_POWER_OFF);
            if (good) begin
                if (inv) begin
                    answer = (r_reg.tag == RTF_READY) || (r_reg.tag == RTF_SELECTED);
                end else if (both) begin
                    answer = 1'b1;
                end else if (sel) begin
                    answer = (r_reg.tag == RTF_SELECTED);
                end else if (addr) begin
                    answer = r_reg.id_ok;
                end else begin
                    answer = (r_reg.tag == RTF_READY) || (r_reg.tag == RTF_SELECTED);
                end
            end
            r_next.last_drop = ~good;
            r_next.last_answ = answer;
            if (good) begin
                r_next.cnt_ok = r_reg.cnt_ok + 16'h0001;
            end else begin
                r_next.cnt_drop = r_reg.cnt_drop + 16'h0001;
            end
            // Response only ever follows a fully checked request
            if (answer) begin
                r_next.resp.start     = 1'b1;
                r_next.resp.flags     = 8'h00;
                r_next.resp.flags[RTF_RS_ERR] = both;
                r_next.resp.error     = both;
                r_next.resp.err_code  = both ? RTF_ERR_OPTION : 8'h00;
                r_next.resp.cmd       = r_reg.cmd;
                r_next.resp.dual_sub  = r_reg.flags[RTF_RQ_SUBC];
                r_next.resp.high_rate = r_reg.flags[RTF_RQ_RATE];
                r_next.resp.ext       = r_reg.flags[RTF_RQ_EXT];
            end
            // State changes carried by state commands
            if (good && !inv && !both) begin
                if (r_reg.cmd == CMD_SELECT) begin
                    if (addressed && r_reg.id_ok) begin
                        r_next.tag = RTF_SELECTED;
                    end else if (r_reg.tag == RTF_SELECTED) begin
                        r_next.tag = RTF_READY;
                    end
                end else if (r_reg.cmd == CMD_STAY_QUIET && addressed && r_reg.id_ok) begin
                    r_next.tag = RTF_QUIET;
                end else if (r_reg.cmd == CMD_RESET_RDY && answer) begin
                    r_next.tag = RTF_READY;
                end
            end
        end

        // Power state has priority over any frame effect on the tag and active flag
        case (r_reg.tag)
            RTF_POWER_OFF: begin
                if (r_reg.field_s || r_reg.vcc_s) begin
                    r_next.tag = RTF_READY;
                end
            end
            RTF_READY, RTF_QUIET, RTF_SELECTED: begin
                if (!r_reg.field_s && !r_reg.vcc_s) begin
                    r_next.tag    = RTF_POWER_OFF;
                    r_next.active = 1'b0;
                end
            end
            default: begin
                r_next.tag = RTF_POWER_OFF;
            end
        endcase

        // APB slave, one wait-free access phase
        setup          = psel & ~penable;
        access         = psel & penable & r_reg.pready;
        r_next.pready  = setup;
        if (setup) begin
            hit            = 1'b1;
            r_next.prdata  = 32'h0000_0000;
            case (paddr)
                RTF_OFS_CTRL:   r_next.prdata[RTF_CTRL_EN_BIT] = r_reg.ctrl_en;
                RTF_OFS_STAT: begin
                    r_next.prdata[RTF_STAT_TAG_LSB +: 2] = r_reg.tag;
                    r_next.prdata[RTF_STAT_DROP]         = r_reg.last_drop;
                    r_next.prdata[RTF_STAT_ANSW]         = r_reg.last_answ;
                end
                RTF_OFS_ID_LO:  r_next.prdata = r_reg.id[31:0];
                RTF_OFS_ID_HI:  r_next.prdata = r_reg.id[63:32];
                RTF_OFS_COUNT:  r_next.prdata = {r_reg.cnt_drop, r_reg.cnt_ok};
                default:        hit = 1'b0;
            endcase
            r_next.pslverr = ~hit;
        end
        if (access && pwrite && !r_reg.pslverr) begin
            case (paddr)
                RTF_OFS_CTRL:   r_next.ctrl_en    = pwdata[RTF_CTRL_EN_BIT];
                RTF_OFS_ID_LO:  r_next.id[31:0]   = pwdata;
                RTF_OFS_ID_HI:  r_next.id[63:32]  = pwdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg           <= '0;
            r_reg.tag       <= RTF_POWER_OFF;
            r_reg.ctrl_en   <= RTF_CTRL_RESET[RTF_CTRL_EN_BIT];
            r_reg.id        <= ID_RESET;
            r_reg.crc       <= RTF_CRC_PRESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign resp      = r_reg.resp;
    assign tag_state = r_reg.tag;
    assign prdata    = r_reg.prdata;
    assign pready    = r_reg.pready;
    assign pslverr   = r_reg.pslverr;

endmodule : rtf_request_filter

// *** src/rtf_pkg.sv ***
package rtf_pkg;

    // Register byte offsets
    localparam logic [7:0]  RTF_OFS_CTRL     = 8'h00;
    localparam logic [7:0]  RTF_OFS_STAT     = 8'h04;
    localparam logic [7:0]  RTF_OFS_ID_LO    = 8'h08;
    localparam logic [7:0]  RTF_OFS_ID_HI    = 8'h0c;
    localparam logic [7:0]  RTF_OFS_COUNT    = 8'h10;

    // Control fields and reset value
    localparam int          RTF_CTRL_EN_BIT  = 0;
    localparam logic [31:0] RTF_CTRL_RESET   = 32'h0000_0001;

    // Status fields
    localparam int          RTF_STAT_TAG_LSB = 0;
    localparam int          RTF_STAT_DROP    = 2;
    localparam int          RTF_STAT_ANSW    = 3;

    // Request flag bit positions (bit 1 of the flag byte is index 0)
    localparam int          RTF_RQ_SUBC      = 0;
    localparam int          RTF_RQ_RATE      = 1;
    localparam int          RTF_RQ_INV       = 2;
    localparam int          RTF_RQ_EXT       = 3;
    localparam int          RTF_RQ_SEL       = 4;
    localparam int          RTF_RQ_AFI       = 4;
    localparam int          RTF_RQ_ADDR      = 5;

    // Response flag bit positions and error codes
    localparam int          RTF_RS_ERR       = 0;
    localparam logic [7:0]  RTF_ERR_OPTION   = 8'h03;

    // Frame check
    localparam logic [15:0] RTF_CRC_PRESET   = 16'hffff;
    localparam logic [15:0] RTF_CRC_POLY     = 16'h8408;
    localparam logic [15:0] RTF_CRC_RESIDUE  = 16'hf0b8;

    // Frame lengths in bytes
    localparam logic [4:0]  RTF_LEN_BASE     = 5'h04;
    localparam logic [4:0]  RTF_LEN_ID       = 5'h08;
    localparam logic [4:0]  RTF_LEN_BYTE     = 5'h01;
    localparam logic [4:0]  RTF_LEN_MAX      = 5'h1f;
    localparam logic [4:0]  RTF_IDX_ID_LO    = 5'h02;
    localparam logic [4:0]  RTF_IDX_ID_HI    = 5'h09;

    typedef enum logic [1:0] {
        RTF_POWER_OFF,
        RTF_READY,
        RTF_QUIET,
        RTF_SELECTED
    } rtf_tag_e;

    // Decoded byte stream from the demodulator
    typedef struct packed {
        logic       sof;
        logic       byte_valid;
        logic [7:0] data;
        logic       eof;
        logic       bit_err;
    } rtf_rx_s;

    // Response frame setup handed to the encoder
    typedef struct packed {
        logic       start;
        logic [7:0] flags;
        logic       error;
        logic [7:0] err_code;
        logic [7:0] cmd;
        logic       dual_sub;
        logic       high_rate;
        logic       ext;
    } rtf_resp_s;

    typedef struct packed {
        logic        field_m;
        logic        field_s;
        logic        vcc_m;
        logic        vcc_s;
        rtf_tag_e    tag;
        logic        ctrl_en;
        logic [63:0] id;
        logic        active;
        logic [4:0]  cnt;
        logic [15:0] crc;
        logic [7:0]  flags;
        logic [7:0]  cmd;
        logic        id_ok;
        logic [63:0] id_sh;
        rtf_resp_s   resp;
        logic        last_drop;
        logic        last_answ;
        logic [15:0] cnt_ok;
        logic [15:0] cnt_drop;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rtf_state_s;

endpackage : rtf_pkg

// *** tb/rtf_reader_model.sv ***
`timescale 1ns/1ps
module rtf_reader_model
    import rtf_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Request stream
    output rtf_rx_s   rx
);
    initial rx = '0;
    // Sends one request; bad 1 spoils the low check byte, bad 2 ends ragged
    task automatic send(input logic [7:0] q[$], input int bad, input int gap);
        logic [15:0] c;
        c = RTF_CRC_PRESET;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ RTF_CRC_POLY : c >> 1;
        end
        c = ~c;
        q.push_back(c[7:0] ^ 8'(bad == 1));
        q.push_back(c[15:8]);
        @(posedge clk) rx.sof <= 1'b1;
        foreach (q[i]) begin
            @(posedge clk) {rx.sof, rx.byte_valid, rx.data} <= {2'b01, q[i]};
            repeat (gap) @(posedge clk) {rx.byte_valid, rx.data} <= {1'b0, ~rx.data};
        end
        @(posedge clk) {rx.byte_valid, rx.eof, rx.bit_err} <= {2'b01, bad == 2};
        @(posedge clk) {rx.eof, rx.bit_err, rx.data} <= {2'b00, ~rx.data};
    endtask : send
endmodule : rtf_reader_model

// *** tb/rtf_request_filter_properties.sv ***
`timescale 1ns/1ps
module rtf_request_filter_checker
    import rtf_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Power pins
    input wire logic        field_ok,
    input wire logic        vcc_ok,
    // Frames
    input wire rtf_rx_s     rx,
    input wire rtf_resp_s   resp,
    input wire rtf_tag_e    tag_state,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    logic [7:0] fl_reg;
    logic       first_reg;
    // Flag byte of the frame in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fl_reg    <= 8'h00;
            first_reg <= 1'b0;
        end else if (rx.sof) begin
            first_reg <= 1'b1;
        end else if (rx.byte_valid && first_reg) begin
            fl_reg    <= rx.data;
            first_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reply_after_eof_a: assert property (resp.start |-> $past(rx.eof) && !$past(rx.byte_valid))
        else $error("answer without end of frame");
    ragged_silent_a: assert property (rx.eof && rx.bit_err && !rx.byte_valid |=> !resp.start)
        else $error("answer to ragged frame");
    error_code_a: assert property (resp.start && resp.error |->
        resp.err_code == RTF_ERR_OPTION && resp.flags == 8'h01) else $error("bad error answer");
    link_flags_a: assert property (resp.start |-> {resp.dual_sub, resp.high_rate, resp.ext} ==
        {fl_reg[RTF_RQ_SUBC], fl_reg[RTF_RQ_RATE], fl_reg[RTF_RQ_EXT]}) else $error("link flags");
    quiet_filter_a: assert property (resp.start && $past(tag_state) == RTF_QUIET |->
        fl_reg[RTF_RQ_ADDR] && !fl_reg[RTF_RQ_INV]) else $error("quiet tag answered");
    select_only_a: assert property (resp.start && fl_reg[RTF_RQ_SEL] && !fl_reg[RTF_RQ_ADDR] &&
        !fl_reg[RTF_RQ_INV] |-> $past(tag_state) == RTF_SELECTED) else $error("select answer");
    off_needs_both_a: assert property (tag_state == RTF_POWER_OFF && $past(tag_state) !=
        RTF_POWER_OFF |-> !$past(field_ok, 3) && !$past(vcc_ok, 3)) else $error("early power off");
    wake_ready_a: assert property (tag_state != RTF_POWER_OFF && $past(tag_state) ==
        RTF_POWER_OFF |-> tag_state == RTF_READY && ($past(field_ok, 3) || $past(vcc_ok, 3)))
        else $error("wake state");
endmodule : rtf_request_filter_checker

bind rtf_request_filter rtf_request_filter_checker i_chk (.clk(clk), .rst_n(rst_n),
    .field_ok(field_ok), .vcc_ok(vcc_ok), .rx(rx), .resp(resp), .tag_state(tag_state),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb
    import rtf_pkg::*;
;
    localparam logic [7:0] C_QUIET = 8'h02;
    localparam logic [7:0] C_SEL   = 8'h25;
    localparam logic [7:0] C_RDY   = 8'h26;
    logic        clk = 1'b0, rst_n = 1'b0, field_ok = 1'b1, vcc_ok = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr;
    rtf_rx_s     rx;
    rtf_resp_s   resp;
    rtf_tag_e    tag_state;
    int          n_errors = 0, n_compared = 0, seed = 32'hba5ea7dd;
    always #2.5 clk = ~clk;
    rtf_reader_model u_reader (.clk(clk), .rx(rx));
    rtf_request_filter #(.CMD_STAY_QUIET(C_QUIET), .CMD_SELECT(C_SEL), .CMD_RESET_RDY(C_RDY))
    i_rtf_request_filter (.clk(clk), .rst_n(rst_n), .field_ok(field_ok), .vcc_ok(vcc_ok),
        .rx(rx), .resp(resp), .tag_state(tag_state), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic conclude;
        if (n_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, xq,
                       input logic xe);
        int n;
        @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk) penable <= 1'b1;
        for (n = 0; n < 9; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 9) begin
            n_errors++;
            conclude();
        end
        chk("pslverr", xe, pslverr);
        if (!w) chk("prdata", xq, prdata);
        {psel, penable} <= 2'b00;
    endtask : apb
    initial begin
        logic [31:0] lo, hi;
        logic [7:0]  b[$], cmds[4], fl, cmd;
        logic        mt, ans, adr, ok, err;
        int          st, bad;
        cmds = '{8'h20, C_SEL, C_QUIET, C_RDY};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk("tag", 1, tag_state);
        apb(0, RTF_OFS_CTRL, 0, RTF_CTRL_RESET, 0);
        apb(0, 8'h14, 0, 0, 1);
        apb(1, RTF_OFS_COUNT, 32'hffff_ffff, 0, 0);
        apb(0, RTF_OFS_COUNT, 0, 0, 0);
        lo = $random(seed);
        hi = $random(seed);
        apb(1, RTF_OFS_ID_LO, lo, 0, 0);
        apb(1, RTF_OFS_ID_HI, hi, 0, 0);
        apb(0, RTF_OFS_ID_HI, 0, hi, 0);
        apb(0, RTF_OFS_ID_LO, 0, lo, 0);
        st = 1;
        for (int i = 0; i < 240; i++) begin
            fl = $random(seed);
            fl[7:6] = 2'b00;
            cmd = cmds[$unsigned($random(seed)) % 4];
            if (cmd inside {C_SEL, C_QUIET}) {fl[5:4], fl[2]} = 3'b100;
            if (fl[5:4] == 2'b11 && !fl[2]) cmd = 8'h20;
            mt = $random(seed);
            bad = $unsigned($random(seed)) % 8;
            adr = fl[5] & !fl[4] & !fl[2];
            b = {fl, cmd};
            for (int k = 0; k < 8 && adr; k++) b.push_back(8'({hi, lo} >> (8 * k)) ^ {8{!mt}});
            if (fl[2] && fl[4]) b.push_back(8'h00);
            if (fl[2]) b.push_back(8'h00);
            if (bad == 3) b = {fl};
            if (i == 100) apb(1, RTF_OFS_CTRL, 0, 0, 0);
            u_reader.send(b, bad, i % 3);
            #1;
            ok = (bad == 0 || bad > 3) && i != 100;
            err = ok && !fl[2] && fl[5:4] == 2'b11;
            ans = 1'b0;
            if (ok && fl[2]) ans = st[0];
            else if (ok && fl[4]) ans = fl[5] | (st == 3);
            else if (ok && fl[5]) ans = mt;
            else if (ok) ans = st[0];
            if (cmd != C_QUIET) begin
                chk("start", ans, resp.start);
                if (ans) chk("resp", {fl[0], fl[1], fl[3], err, 7'h0, err, cmd},
                    {resp.dual_sub, resp.high_rate, resp.ext, resp.error, resp.flags, resp.cmd});
            end
            if (ok && adr && cmd == C_SEL) st = mt ? 3 : (st == 3 ? 1 : st);
            if (ok && adr && cmd == C_QUIET && mt) st = 2;
            if (ans && cmd == C_RDY && !fl[2]) st = 1;
            chk("tag", st, tag_state);
            if (i == 100) apb(1, RTF_OFS_CTRL, 1, 0, 0);
            if (i % 40 == 39) begin
                @(posedge clk) vcc_ok <= 1'b1;
                @(posedge clk) field_ok <= 1'b0;
                repeat (6) @(posedge clk);
                chk("tag", st, tag_state);
                @(posedge clk) vcc_ok <= 1'b0;
                repeat (6) @(posedge clk);
                chk("tag", 0, tag_state);
                @(posedge clk) field_ok <= 1'b1;
                repeat (6) @(posedge clk);
                chk("tag", 1, tag_state);
                st = 1;
            end
        end
        conclude();
    end
endmodule : tb
